/* File: rtl/sfc_format.v */
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"
// ==========================================
// Operation
// (RQ1) bit 7 picks asynchronous (0) or clocked synchronous (1) mode.
// (RQ2) in asynchronous mode char length bit 0 gives 8 data bits, 1 gives 7.
// (RQ3) with 7-bit characters the frame is lsb first and bit 7 is dropped.
// (RQ4) clocked synchronous mode always uses 8 bits, ignoring char length.
// (RQ5) parity enable in asynchronous mode adds and checks a parity bit.
// (RQ6) multiprocessor format never adds nor checks parity.
// (RQ7) parity mode 0 is even, 1 is odd, for generation and checking.
// (RQ8) stop length 0 sends one stop bit, 1 sends two.
// (RQ9) the receiver checks only the first stop bit, a low second is a start.
// (RQ10) multiprocessor bit in asynchronous mode adds the multiprocessor bit.
// (RQ11) clock source 00 undivided, 01 by 4, 10 by 16, 11 by 64.
// (RQ12) the clock source field is given out as prescale index n.
// (RQ13) stop, multiprocessor, length and parity are ignored when synchronous.
// (RQ14) with card interface select set, bits 7 to 2 take the card layout.
// (RQ15) card cycles per bit: 00 is 32, 01 is 64, 10 is 372, 11 is 256.
// (RQ16) card timing variant moves transmit end to 11.0 etu, enables clock ctl.
module sfc_format (
   input wire clk_i,
   input wire rst_n_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] tx_holding_i,
   output reg [7:0] rdata_o,
   output reg sync_mode_o,
   output reg [3:0] data_bits_o,
   output reg [7:0] tx_char_o,
   output reg lsb_first_o,
   output reg parity_gen_o,
   output reg parity_chk_o,
   output reg parity_odd_o,
   output reg [1:0] tx_stop_bits_o,
   output reg [1:0] rx_stop_check_o,
   output reg multiproc_o,
   output reg [1:0] prescale_n_o,
   output wire baud_tick_o,
   output reg card_mode_o,
   output reg block_transfer_o,
   output reg [8:0] card_cycles_o,
   output reg [4:0] tend_half_etu_o,
   output reg clock_out_ctl_o
);
   reg [7:0] serial_format_reg_q;
   reg [7:0] card_mode_reg_q;
   reg lsb_cfg_q;
   wire card_sel;
   wire async_n;
   wire multiproc_on;
   wire parity_on;
   wire timing_var_on;
   wire [1:0] cks;
   // ==========================================
   // register writes
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_format_reg_q <= `SFC_RST_FORMAT;
         card_mode_reg_q <= `SFC_RST_CARD;
         lsb_cfg_q <= 1'b1;
      end else if (wr_i) begin
         if (addr_i == `SFC_OFF_FORMAT) begin
            serial_format_reg_q <= wdata_i;
         end
         if (addr_i == `SFC_OFF_CARD) begin
            card_mode_reg_q <= wdata_i;
         end
         if (addr_i == `SFC_OFF_CFG) begin
            lsb_cfg_q <= wdata_i[0];
         end
      end
   end
   assign card_sel = card_mode_reg_q[`SFC_B_CARD_SEL];
   assign async_n = serial_format_reg_q[`SFC_B_COMM] & ~card_sel; // [RQ1]
   assign multiproc_on = ~async_n & ~card_sel &
                         serial_format_reg_q[`SFC_B_MULTIPROC]; // [RQ10]
   assign parity_on = serial_format_reg_q[`SFC_B_PAR_EN] &
                      ~multiproc_on; // [RQ6]
   assign timing_var_on = card_sel &
                          serial_format_reg_q[`SFC_B_TIMING_VAR]; // [RQ16]
   assign cks = {serial_format_reg_q[`SFC_B_CKS_HI],
                 serial_format_reg_q[`SFC_B_CKS_LO]};
   // ==========================================
   // prescaler
   sfc_prescale u_pre (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sel_i(cks), // [RQ11]
      .tick_o(baud_tick_o)
   );
   // ==========================================
   // decoded format, registered
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_mode_o <= 1'b0;
         data_bits_o <= 4'h8;
         tx_char_o <= 8'h00;
         lsb_first_o <= 1'b1;
         parity_gen_o <= 1'b0;
         parity_chk_o <= 1'b0;
         parity_odd_o <= 1'b0;
         tx_stop_bits_o <= 2'h1;
         rx_stop_check_o <= 2'h1;
         multiproc_o <= 1'b0;
         prescale_n_o <= 2'h0;
         card_mode_o <= 1'b0;
         block_transfer_o <= 1'b0;
         card_cycles_o <= `SFC_CYC0;
         tend_half_etu_o <= `SFC_STD_TEND_HALF;
         clock_out_ctl_o <= 1'b0;
      end else begin
         sync_mode_o <= async_n; // [RQ1]
         card_mode_o <= card_sel; // [RQ14]
         prescale_n_o <= cks; // [RQ12]
         rx_stop_check_o <= 2'h1; // [RQ9]
         if (async_n) begin
            data_bits_o <= 4'h8; // [RQ4] [RQ13]
            tx_char_o <= tx_holding_i;
            lsb_first_o <= lsb_cfg_q;
            parity_gen_o <= 1'b0; // [RQ13]
            parity_chk_o <= 1'b0;
            tx_stop_bits_o <= 2'h1;
            multiproc_o <= 1'b0;
         end else if (!card_sel && serial_format_reg_q[`SFC_B_CHAR_LEN]) begin
            data_bits_o <= 4'h7; // [RQ2]
            tx_char_o <= {1'b0, tx_holding_i[6:0]}; // [RQ3]
            lsb_first_o <= 1'b1; // [RQ3]
         end else begin
            data_bits_o <= 4'h8; // [RQ2]
            tx_char_o <= tx_holding_i;
            lsb_first_o <= lsb_cfg_q;
         end
         if (!async_n) begin
            parity_gen_o <= parity_on; // [RQ5] [RQ6]
            parity_chk_o <= parity_on; // [RQ5] [RQ6]
            multiproc_o <= multiproc_on; // [RQ10]
            if (card_sel) begin
               tx_stop_bits_o <= 2'h1;
            end else if (serial_format_reg_q[`SFC_B_STOP]) begin
               tx_stop_bits_o <= 2'h2; // [RQ8]
            end else begin
               tx_stop_bits_o <= 2'h1; // [RQ8]
            end
         end
         parity_odd_o <= serial_format_reg_q[`SFC_B_ODD] & ~async_n; // [RQ7]
         block_transfer_o <= card_sel &
                             serial_format_reg_q[`SFC_B_BLOCK]; // [RQ14]
         clock_out_ctl_o <= timing_var_on; // [RQ16]
         if (timing_var_on) begin
            tend_half_etu_o <= `SFC_VAR_TEND_HALF; // [RQ16]
         end else begin
            tend_half_etu_o <= `SFC_STD_TEND_HALF;
         end
         case ({serial_format_reg_q[`SFC_B_BCP_HI],
                serial_format_reg_q[`SFC_B_BCP_LO]})
            2'h0: card_cycles_o <= `SFC_CYC0; // [RQ15]
            2'h1: card_cycles_o <= `SFC_CYC1; // [RQ15]
            2'h2: card_cycles_o <= `SFC_CYC2; // [RQ15]
            default: card_cycles_o <= `SFC_CYC3; // [RQ15]
         endcase
      end
   end
   // ==========================================
   // read port
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `SFC_OFF_FORMAT: rdata_o <= serial_format_reg_q;
            `SFC_OFF_CARD: rdata_o <= card_mode_reg_q;
            `SFC_OFF_CFG: rdata_o <= {7'h00, lsb_cfg_q};
            `SFC_OFF_STAT: rdata_o <= {data_bits_o, 1'b0, parity_gen_o,
                                      sync_mode_o, card_mode_o};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule // sfc_format
`default_nettype wire

/* File: rtl/sfc_map.vh */
`ifndef SFC_MAP_VH
`define SFC_MAP_VH
// ==========================================
// register offsets
`define SFC_ADDR_W 4
`define SFC_OFF_FORMAT 4'h0
`define SFC_OFF_CARD 4'h1
`define SFC_OFF_CFG 4'h2
`define SFC_OFF_STAT 4'h3
// ==========================================
// format register fields, normal layout
`define SFC_B_COMM 7
`define SFC_B_CHAR_LEN 6
`define SFC_B_PAR_EN 5
`define SFC_B_ODD 4
`define SFC_B_STOP 3
`define SFC_B_MULTIPROC 2
`define SFC_B_CKS_HI 1
`define SFC_B_CKS_LO 0
// format register fields, card layout
`define SFC_B_TIMING_VAR 7
`define SFC_B_BLOCK 6
`define SFC_B_BCP_HI 3
`define SFC_B_BCP_LO 2
// card mode register field
`define SFC_B_CARD_SEL 0
// ==========================================
// reset values
`define SFC_RST_FORMAT 8'h00
`define SFC_RST_CARD 8'h00
// ==========================================
// prescale divide counts
`define SFC_DIV0 7'h01
`define SFC_DIV1 7'h04
`define SFC_DIV2 7'h10
`define SFC_DIV3 7'h40
// card cycles per bit
`define SFC_CYC0 9'h020
`define SFC_CYC1 9'h040
`define SFC_CYC2 9'h174
`define SFC_CYC3 9'h100
// card transmit end point, in half etu
`define SFC_VAR_TEND_HALF 5'h16
`define SFC_STD_TEND_HALF 5'h18
`endif

/* File: rtl/sfc_prescale.v */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"
// ==========================================
// baud generator input prescaler
module sfc_prescale (
   input wire clk_i,
   input wire rst_n_i,
   input wire [1:0] sel_i,
   output wire tick_o
);
   reg [6:0] cnt_q;
   reg [6:0] cnt_d;
   reg [6:0] lim;
   always @* begin
      case (sel_i)
         2'h0: lim = `SFC_DIV0;
         2'h1: lim = `SFC_DIV1;
         2'h2: lim = `SFC_DIV2;
         default: lim = `SFC_DIV3;
      endcase
   end
   assign tick_o = (cnt_q >= lim - 7'h01);
   always @* begin
      if (tick_o) begin
         cnt_d = 7'h00;
      end else begin
         cnt_d = cnt_q + 7'h01;
      end
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // sfc_prescale
`default_nettype wire

/* File: tb/sfc_format_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// format decode checker
module sfc_format_props (
   input wire clk_i,
   input wire rst_n_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire sync_mode_o,
   input wire [3:0] data_bits_o,
   input wire [7:0] tx_char_o,
   input wire lsb_first_o,
   input wire parity_gen_o,
   input wire parity_chk_o,
   input wire multiproc_o,
   input wire [1:0] tx_stop_bits_o,
   input wire [1:0] rx_stop_check_o,
   input wire [1:0] prescale_n_o,
   input wire baud_tick_o,
   input wire card_mode_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence fmt_wr;
      wr_i && addr_i == 4'h0 && !card_mode_o ##2 !card_mode_o;
   endsequence
   sequence cks_wr;
      wr_i && addr_i == 4'h0 ##2 1'b1;
   endsequence
   mode_follow_a: assert property (
      fmt_wr |-> sync_mode_o == $past(wdata_i[7], 2)) else $error("mode");
   clk_index_a: assert property (
      cks_wr |-> prescale_n_o == $past(wdata_i[1:0], 2)) else $error("index");
   sync_len_a: assert property (
      sync_mode_o |-> data_bits_o == 4'h8) else $error("sync length");
   short_char_a: assert property (
      data_bits_o == 4'h7 |-> lsb_first_o && !tx_char_o[7]) else $error("7b");
   multiproc_parity_a: assert property (
      multiproc_o |-> !parity_gen_o && !parity_chk_o)
      else $error("multiproc parity");
   sync_ignore_a: assert property (
      sync_mode_o |-> !parity_gen_o && !multiproc_o && tx_stop_bits_o == 2'h1)
      else $error("sync ignore");
   stop_check_a: assert property (
      rx_stop_check_o == 2'h1) else $error("rx stop");
   div4_tick_a: assert property (
      (prescale_n_o == 2'h1)[*4] |-> $countones({$past(baud_tick_o),
      $past(baud_tick_o, 2), $past(baud_tick_o, 3),
      $past(baud_tick_o, 4)}) == 1)
      else $error("div4");
   card_stop_a: assert property (
      card_mode_o |-> tx_stop_bits_o == 2'h1 && !sync_mode_o)
      else $error("card");
endmodule // sfc_format_props
bind sfc_format sfc_format_props i_sfc_format_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .sync_mode_o(sync_mode_o), .data_bits_o(data_bits_o),
   .tx_char_o(tx_char_o), .lsb_first_o(lsb_first_o),
   .parity_gen_o(parity_gen_o), .parity_chk_o(parity_chk_o),
   .multiproc_o(multiproc_o), .tx_stop_bits_o(tx_stop_bits_o),
   .rx_stop_check_o(rx_stop_check_o), .prescale_n_o(prescale_n_o),
   .baud_tick_o(baud_tick_o), .card_mode_o(card_mode_o)
);
`default_nettype wire

/* File: tb/sfc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// far side: supplies the character to send
module sfc_peer #(parameter logic [7:0] CHAR = 8'hd5) (
   output logic [7:0] hold_o
);
   assign hold_o = CHAR;
endmodule // sfc_peer
`default_nettype wire

/* File: tb/test_serial_mode_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"
`define CK(a,b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
$display("ERROR %0t got %h exp %h", $time, a, b); end end
// ====================
// bench
module test_serial_mode_config;
   logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   wire [7:0] tx_holding_i, rdata_o, tx_char_o;
   wire [3:0] data_bits_o;
   wire [1:0] tx_stop_bits_o, rx_stop_check_o, prescale_n_o;
   wire [8:0] card_cycles_o;
   wire [4:0] tend_half_etu_o;
   wire sync_mode_o, lsb_first_o, parity_gen_o, parity_chk_o, parity_odd_o,
      multiproc_o, baud_tick_o, card_mode_o, block_transfer_o, clock_out_ctl_o;
   logic [8:0] cy [4] = '{`SFC_CYC0, `SFC_CYC1, `SFC_CYC2, `SFC_CYC3};
   logic [4:0] te [2] = '{`SFC_STD_TEND_HALF, `SFC_VAR_TEND_HALF};
   int fail_count = 0, check_count = 0, n, k;
   sfc_peer i_sfc_peer (.hold_o(tx_holding_i));
   sfc_format i_sfc_format (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .tx_holding_i(tx_holding_i),
      .rdata_o(rdata_o), .sync_mode_o(sync_mode_o),
      .data_bits_o(data_bits_o), .tx_char_o(tx_char_o),
      .lsb_first_o(lsb_first_o), .parity_gen_o(parity_gen_o),
      .parity_chk_o(parity_chk_o), .parity_odd_o(parity_odd_o),
      .tx_stop_bits_o(tx_stop_bits_o), .rx_stop_check_o(rx_stop_check_o),
      .multiproc_o(multiproc_o), .prescale_n_o(prescale_n_o),
      .baud_tick_o(baud_tick_o), .card_mode_o(card_mode_o),
      .block_transfer_o(block_transfer_o), .card_cycles_o(card_cycles_o),
      .tend_half_etu_o(tend_half_etu_o), .clock_out_ctl_o(clock_out_ctl_o)
   );
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      `CK(rdata_o, e)
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial forever #5 clk_i = ~clk_i;
   initial begin
      #50000;
      fail_count++;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      `CK({data_bits_o, tx_stop_bits_o}, {4'h8, 2'h1})
      rd(`SFC_OFF_FORMAT, 8'h00);
      wr(`SFC_OFF_FORMAT, 8'h40);
      `CK({data_bits_o, lsb_first_o, tx_char_o}, {4'h7, 1'b1, 8'h55})
      rd(`SFC_OFF_STAT, 8'h70);
      wr(`SFC_OFF_FORMAT, 8'h00);
      `CK({data_bits_o, tx_char_o}, {4'h8, 8'hd5})
      wr(`SFC_OFF_FORMAT, 8'h38);
      `CK({parity_gen_o, parity_chk_o, parity_odd_o}, 3'h7)
      `CK(tx_stop_bits_o, 2'h2)
      `CK(rx_stop_check_o, 2'h1)
      wr(`SFC_OFF_FORMAT, 8'h20);
      `CK({parity_gen_o, parity_chk_o, parity_odd_o}, 3'h6)
      wr(`SFC_OFF_FORMAT, 8'h34);
      `CK({parity_gen_o, parity_chk_o, multiproc_o}, 3'h1)
      rd(`SFC_OFF_FORMAT, 8'h34);
      wr(`SFC_OFF_FORMAT, 8'hfc);
      `CK({sync_mode_o, multiproc_o, data_bits_o}, 6'h28)
      `CK({parity_gen_o, parity_chk_o, tx_stop_bits_o}, 4'h1)
      rd(`SFC_OFF_STAT, 8'h82);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      $display("test format done");
      for (n = 0; n < 4; n++) begin
         wr(`SFC_OFF_FORMAT, n[7:0]);
         `CK(prescale_n_o, n[1:0])
         k = 0;
         repeat (64) @(negedge clk_i) k += baud_tick_o;
         `CK(k, 64 >> (2 * n))
      end
      $display("test prescale done");
      wr(`SFC_OFF_CFG, 8'h00);
      `CK({lsb_first_o, data_bits_o}, {1'b0, 4'h8})
      rd(`SFC_OFF_CFG, 8'h00);
      wr(`SFC_OFF_FORMAT, 8'h40);
      `CK({lsb_first_o, data_bits_o}, {1'b1, 4'h7})
      wr(`SFC_OFF_FORMAT, 8'hc0);
      `CK({sync_mode_o, lsb_first_o, data_bits_o}, 6'h28)
      `CK(tx_char_o, 8'hd5)
      $display("test order done");
      wr(`SFC_OFF_CARD, 8'h01);
      for (n = 0; n < 4; n++) begin
         wr(`SFC_OFF_FORMAT, {n[0], n[1], 2'h2, n[1:0], 2'h0});
         `CK(card_cycles_o, cy[n])
         `CK(tend_half_etu_o, te[n[0]])
         `CK(clock_out_ctl_o, n[0])
         `CK(card_mode_o, 1'b1)
         `CK({sync_mode_o, block_transfer_o}, {1'b0, n[1]})
      end
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`SFC_OFF_CARD, 8'h00);
      rd(`SFC_OFF_CFG, 8'h01);
      $display("test card done");
      end_of_test;
   end
endmodule // test_serial_mode_config
`default_nettype wire
